// ==== logic/ssi_defines.vh ====
// Purpose: Constants for the serial interface block
// Assumes: One 100 MHz clock, no register bus beyond the pins
// Notes: Field positions are bit ranges used as index expressions
// Summary of operation
// - Chip select low performs the access chosen by direction and select lines
// - Chip select high keeps all eight data lines undriven
// - Direction low makes the device drive data; high makes it accept data
// - Direction line is ignored while chip select is high
// - Data path is eight bits, bit 0 least significant
// - Bit clock comes from external clocks or sixteen internal divided rates
// - Asynchronous bit clock is 1, 16 or 64 times the baud rate
// - Characters are five to eight bits with odd, even or no parity
// - Asynchronous frames use one, one and a half or two stop bits
// - Synchronous receiver aligns itself on one or two sync characters
// - Three loadable bytes hold first sync, second sync and escape
// - Transmitter fills with sync or escape-sync; receiver strips sync and escape, keeps a sync after escape
// - Asynchronous break is sent and detected; false starts are rejected at 16X and 64X
// - Parity, overrun and framing errors are reported in status
// - Local and remote loopback exist in both modes
// - Asynchronous echo resends received data on the serial output
// - Receiver assembles characters and holds them until read
// - Transmitter serialises characters adding framing bits or characters
// - Both directions are double buffered
// - Three modem outputs and three modem inputs
// - Rates reach 1 Mbaud sync or 1X, 62.5 k at 16X, 15.625 k at 64X
// - Receive ready low while a character waits; high after read or disable
// - Transmit ready low while holding register free and transmitter on
// - Reset clears mode, command and status and idles the device
// - Disabled transmitter holds the serial output at mark except in remote loop or asynchronous echo
`ifndef SSI_DEFINES_VH
`define SSI_DEFINES_VH
// Register selects
`define SSI_A_DATA 2'h0
`define SSI_A_STAT 2'h1
`define SSI_A_MODE 2'h2
`define SSI_A_CMD 2'h3
`define SSI_RST8 8'h00
// First mode byte fields
`define SSI_M1_CLK 1:0
`define SSI_M1_LEN 3:2
`define SSI_M1_PEN 4
`define SSI_M1_EVEN 5
`define SSI_M1_STOP 7:6
`define SSI_M1_TRANS 6
`define SSI_M1_ONESYN 7
// Second mode byte fields
`define SSI_M2_RATE 3:0
`define SSI_M2_RXINT 4
`define SSI_M2_TXINT 5
// Command fields
`define SSI_C_TXEN 0
`define SSI_C_DTR 1
`define SSI_C_RXEN 2
`define SSI_C_BRK 3
`define SSI_C_ERST 4
`define SSI_C_RTS 5
`define SSI_C_LOOP 7:6
// Clock modes and loop modes
`define SSI_CK_SYNC 2'h0
`define SSI_CK_X1 2'h1
`define SSI_CK_X16 2'h2
`define SSI_LP_ECHO 2'h1
`define SSI_LP_LOCAL 2'h2
`define SSI_LP_REMOTE 2'h3
`define SSI_ST_ONEHALF 2'h2
`define SSI_ST_TWO 2'h3
// Character sizes
`define SSI_LEN_MIN 4'h5
`define SSI_RSH_W 4'ha
// Internal baud table
`define SSI_B0 50
`define SSI_B1 75
`define SSI_B2 110
`define SSI_B3 150
`define SSI_B4 300
`define SSI_B5 600
`define SSI_B6 1200
`define SSI_B7 1800
`define SSI_B8 2000
`define SSI_B9 2400
`define SSI_B10 3600
`define SSI_B11 4800
`define SSI_B12 7200
`define SSI_B13 9600
`define SSI_B14 14400
`define SSI_B15 19200
`endif

// ==== logic/ssi_top.v ====
// Purpose: Synchronous/asynchronous serial interface with processor bus
// Assumes: Bus pins and line pins are asynchronous to mclk_i
// Notes: Bus accesses take effect when chip select rises again
`timescale 1ns/10ps
`include "ssi_defines.vh"
module ssi_top #(
   parameter REF_HZ = 100000000
) (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Processor bus
   input wire cs_n_i,
   input wire rw_i,
   input wire [1:0] register_select_i,
   input wire [7:0] host_data_bus_i,
   output reg [7:0] host_data_bus_o,
   output reg host_data_bus_oe_o,
   // Serial line and external clocks
   input wire rxd_i,
   input wire tx_clk_i,
   input wire rx_clk_i,
   output reg txd_o,
   // Modem handshake
   input wire cts_n_i,
   input wire dcd_n_i,
   input wire dsr_n_i,
   output reg dtr_n_o,
   output reg rts_n_o,
   output reg tx_empty_n_o,
   // Ready and break indications
   output reg rx_char_waiting_n_o,
   output reg tx_holding_free_n_o,
   output reg break_det_o
);
   localparam R_HUNT = 2'h0;
   localparam R_START = 2'h1;
   localparam R_BIT = 2'h2;
   localparam R_MARK = 2'h3;

   // Baud divisor per rate code, ticks of one baud
   function [21:0] bdiv(input [3:0] s);
      reg [31:0] q;
      begin
         case (s)
            4'h0: q = REF_HZ / `SSI_B0;
            4'h1: q = REF_HZ / `SSI_B1;
            4'h2: q = REF_HZ / `SSI_B2;
            4'h3: q = REF_HZ / `SSI_B3;
            4'h4: q = REF_HZ / `SSI_B4;
            4'h5: q = REF_HZ / `SSI_B5;
            4'h6: q = REF_HZ / `SSI_B6;
            4'h7: q = REF_HZ / `SSI_B7;
            4'h8: q = REF_HZ / `SSI_B8;
            4'h9: q = REF_HZ / `SSI_B9;
            4'ha: q = REF_HZ / `SSI_B10;
            4'hb: q = REF_HZ / `SSI_B11;
            4'hc: q = REF_HZ / `SSI_B12;
            4'hd: q = REF_HZ / `SSI_B13;
            4'he: q = REF_HZ / `SSI_B14;
            default: q = REF_HZ / `SSI_B15;
         endcase
         bdiv = q[21:0]; // Slowest rate at full reference still fits
      end
   endfunction

   // Mask of the programmed character length
   function [7:0] cmask(input [3:0] n);
      cmask = 8'hff >> (4'h8 - n);
   endfunction

   // Parity bit over the masked character
   function pbit(input [7:0] d, input even);
      pbit = ^d ^ ~even;
   endfunction

   // Two-stage input synchroniser
   reg [17:0] in_a;
   reg [17:0] in_s;
   wire cs_s, rw_s, rxd_s, txc_s, rxc_s, cts_s, dcd_s, dsr_s;
   wire [1:0] sel_s;
   wire [7:0] din_s;
   assign {cs_s, rw_s, sel_s, din_s, rxd_s, txc_s, rxc_s, cts_s, dcd_s, dsr_s} = in_s;

   // Programming registers and bus latches
   reg [7:0] mr1, mr2, cmd, first_sync_char, second_sync_char, dle, transmit_holding_reg, receive_holding_reg;
   reg mptr;
   reg [1:0] sptr;
   reg cs_q, lat_rw, txc_q, rxc_q;
   reg [1:0] lat_a;
   reg [7:0] lat_d;
   // Status flags
   reg thr_full, rx_full, pe, ovr, fe, synced;
   // Timing
   reg [21:0] div_r, icnt;
   // Receiver
   reg [1:0] rst;
   reg [5:0] rcnt;
   reg [3:0] rbits;
   reg [9:0] rsh;
   reg need2, dle_pend;
   // Transmitter
   reg tbusy, tdle;
   reg [6:0] tcnt;
   reg [3:0] tbits;
   reg [11:0] tsh;

   wire acc_end = cs_s & ~cs_q;
   wire wr_end = acc_end & lat_rw;
   wire rd_end = acc_end & ~lat_rw;
   wire asy = mr1[`SSI_M1_CLK] != `SSI_CK_SYNC;
   wire [2:0] sh = (mr1[`SSI_M1_CLK] == `SSI_CK_X16) ? 3'h4 :
                   (mr1[`SSI_M1_CLK] == `SSI_CK_X1 || !asy) ? 3'h0 : 3'h6;
   wire [6:0] fact = 7'h01 << sh;
   wire [3:0] clen = {2'h0, mr1[`SSI_M1_LEN]} + `SSI_LEN_MIN;
   wire [7:0] msk = cmask(clen);
   wire par = mr1[`SSI_M1_PEN];
   wire [3:0] rtot = clen + {3'h0, par} + {3'h0, asy};
   wire [1:0] lp = cmd[`SSI_C_LOOP];
   wire tx_en = cmd[`SSI_C_TXEN];
   wire rx_on = cmd[`SSI_C_RXEN] & ~dcd_s;
   wire itick = icnt == 22'h00_0000;
   // External clock edges or internal divider
   wire rtick = mr2[`SSI_M2_RXINT] ? itick : (rxc_s & ~rxc_q);
   wire ttick = mr2[`SSI_M2_TXINT] ? itick : (~txc_s & txc_q);
   wire tline = tbusy ? tsh[0] : 1'b1;
   wire rin = (lp == `SSI_LP_LOCAL) ? tline : rxd_s;
   wire [9:0] next_rsh = {rin, rsh[9:1]};
   wire [9:0] ral = next_rsh >> (`SSI_RSH_W - rtot);
   wire [7:0] rchar = ral[7:0] & msk;
   wire rpar = ral[clen];
   wire rstop = ral[clen + {3'h0, par}];
   wire [9:0] hal = next_rsh >> (`SSI_RSH_W - clen);
   wire hmatch = (hal[7:0] & msk) == (first_sync_char & msk);
   wire rdone = (rst == R_BIT) & rtick & (rcnt == 6'h00) & (rbits == rtot - 4'h1);
   wire [7:0] status = {~dsr_s, ~dcd_s, asy ? fe : synced, ovr, pe,
                        ~tbusy & ~thr_full, rx_full, ~thr_full};
   // Stop length in ticks, rounded to whole ticks at 1X
   wire [6:0] stopt = (mr1[`SSI_M1_STOP] == `SSI_ST_TWO) ? fact << 1 :
                      (mr1[`SSI_M1_STOP] == `SSI_ST_ONEHALF) ? fact + (fact >> 1) :
                      fact;
   // Next character for the transmitter: data, then sync fill
   wire tfill = ~thr_full;
   wire [7:0] tsrc = thr_full ? transmit_holding_reg : (mr1[`SSI_M1_TRANS] & ~tdle ? dle : first_sync_char);
   wire [7:0] tdm = tsrc & msk;
   wire [8:0] tbody = {1'b0, tdm} | ({8'h00, par & pbit(tdm, mr1[`SSI_M1_EVEN])} << clen);
   wire tgo = tx_en & ~cts_s & (thr_full | ~asy);

   // Synchronise every asynchronous pin
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_a <= 18'h3_ffff;
         in_s <= 18'h3_ffff;
      end else begin
         in_a <= {cs_n_i, rw_i, register_select_i, host_data_bus_i,
                  rxd_i, tx_clk_i, rx_clk_i, cts_n_i, dcd_n_i, dsr_n_i};
         in_s <= in_a;
      end
   end

   // Processor bus: latch while selected, act when select ends
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_q <= 1'b1;
         lat_rw <= 1'b0;
         lat_a <= `SSI_A_DATA;
         lat_d <= `SSI_RST8;
         mr1 <= `SSI_RST8;
         mr2 <= `SSI_RST8;
         cmd <= `SSI_RST8;
         first_sync_char <= `SSI_RST8;
         second_sync_char <= `SSI_RST8;
         dle <= `SSI_RST8;
         mptr <= 1'b0;
         sptr <= 2'h0;
         host_data_bus_o <= `SSI_RST8;
         host_data_bus_oe_o <= 1'b0;
      end else begin
         cs_q <= cs_s;
         if (!cs_s) begin
            lat_rw <= rw_s;
            lat_a <= sel_s;
            lat_d <= din_s;
         end
         // Drive only while selected for a read
         host_data_bus_oe_o <= ~cs_s & ~rw_s;
         case (sel_s)
            `SSI_A_DATA: host_data_bus_o <= receive_holding_reg;
            `SSI_A_STAT: host_data_bus_o <= status;
            `SSI_A_MODE: host_data_bus_o <= mptr ? mr2 : mr1;
            default: host_data_bus_o <= cmd;
         endcase
         if (wr_end && lat_a == `SSI_A_MODE) begin
            if (mptr)
               mr2 <= lat_d;
            else
               mr1 <= lat_d;
            mptr <= ~mptr;
         end
         // Sync, second sync and escape bytes load in turn
         if (wr_end && lat_a == `SSI_A_STAT) begin
            case (sptr)
               2'h0: first_sync_char <= lat_d;
               2'h1: second_sync_char <= lat_d;
               default: dle <= lat_d;
            endcase
            sptr <= (sptr == 2'h2) ? 2'h0 : sptr + 2'h1;
         end
         if (wr_end && lat_a == `SSI_A_CMD)
            cmd <= lat_d;
         // Reading the command restarts both load sequences
         if (rd_end && lat_a == `SSI_A_CMD) begin
            mptr <= 1'b0;
            sptr <= 2'h0;
         end
      end
   end

   // Internal rate generator, shared by both directions
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= 22'h00_0001;
         icnt <= 22'h00_0000;
         txc_q <= 1'b1;
         rxc_q <= 1'b1;
      end else begin
         div_r <= bdiv(mr2[`SSI_M2_RATE]) >> sh;
         icnt <= (itick || icnt >= div_r) ? div_r - 22'h00_0001 : icnt - 22'h00_0001;
         txc_q <= txc_s;
         rxc_q <= rxc_s;
      end
   end

   // Receiver: hunt or start, sample bits, check and hold
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst <= R_HUNT;
         rcnt <= 6'h00;
         rbits <= 4'h0;
         rsh <= 10'h3ff;
         need2 <= 1'b0;
         dle_pend <= 1'b0;
         synced <= 1'b0;
         receive_holding_reg <= `SSI_RST8;
         rx_full <= 1'b0;
         pe <= 1'b0;
         ovr <= 1'b0;
         fe <= 1'b0;
         break_det_o <= 1'b0;
      end else begin
         // Clears first so a same-cycle event wins
         if (rd_end && lat_a == `SSI_A_DATA)
            rx_full <= 1'b0;
         if (wr_end && lat_a == `SSI_A_CMD && lat_d[`SSI_C_ERST]) begin
            pe <= 1'b0;
            ovr <= 1'b0;
            fe <= 1'b0;
            break_det_o <= 1'b0;
         end
         if (!rx_on) begin
            rst <= R_HUNT;
            synced <= 1'b0;
            need2 <= 1'b0;
            dle_pend <= 1'b0;
            rx_full <= 1'b0;
         end else if (rtick) begin
            case (rst)
               R_HUNT: begin
                  rsh <= next_rsh;
                  rcnt <= 6'h00;
                  rbits <= 4'h0;
                  if (asy && !rin && mr1[`SSI_M1_CLK] == `SSI_CK_X1) begin
                     // At 1X this tick already sits mid start bit
                     rst <= R_BIT;
                  end else if (asy && !rin) begin
                     rcnt <= fact[6:1] - 6'h01; // Check again at mid start
                     rst <= R_START;
                  end else if (!asy && hmatch) begin
                     rst <= R_BIT;
                     need2 <= ~mr1[`SSI_M1_ONESYN];
                     synced <= mr1[`SSI_M1_ONESYN];
                  end
               end
               R_START: begin
                  if (rcnt != 6'h00)
                     rcnt <= rcnt - 6'h01;
                  else if (rin)
                     rst <= R_HUNT;
                  else begin
                     rcnt <= fact[5:0] - 6'h01;
                     rst <= R_BIT;
                  end
               end
               R_BIT: begin
                  if (rcnt != 6'h00)
                     rcnt <= rcnt - 6'h01;
                  else begin
                     rcnt <= fact[5:0] - 6'h01;
                     rsh <= next_rsh;
                     rbits <= rdone ? 4'h0 : rbits + 4'h1;
                  end
               end
               R_MARK: if (rin) rst <= R_HUNT;
               default: rst <= R_HUNT;
            endcase
            if (rdone && asy) begin
               receive_holding_reg <= rchar;
               rx_full <= 1'b1;
               if (rx_full) ovr <= 1'b1;
               if (par && rpar != pbit(rchar, mr1[`SSI_M1_EVEN])) pe <= 1'b1;
               if (!rstop) fe <= 1'b1;
               if (!rstop && rchar == 8'h00 && !(par && rpar)) break_det_o <= 1'b1;
               rst <= rstop ? R_HUNT : R_MARK;
            end else if (rdone && need2) begin
               // Second sync must follow directly or hunting resumes
               need2 <= 1'b0;
               synced <= rchar == (second_sync_char & msk);
               if (rchar != (second_sync_char & msk)) rst <= R_HUNT;
            end else if (rdone) begin
               dle_pend <= 1'b0;
               if (!dle_pend && rchar == (first_sync_char & msk)) begin
                  dle_pend <= 1'b0;
               end else if (!dle_pend && mr1[`SSI_M1_TRANS] && rchar == (dle & msk)) begin
                  dle_pend <= 1'b1;
               end else begin
                  receive_holding_reg <= rchar;
                  rx_full <= 1'b1;
                  if (rx_full) ovr <= 1'b1;
                  if (par && rpar != pbit(rchar, mr1[`SSI_M1_EVEN])) pe <= 1'b1;
               end
            end
         end
      end
   end

   // Transmitter: holding register feeds the shifter
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         transmit_holding_reg <= `SSI_RST8;
         thr_full <= 1'b0;
         tbusy <= 1'b0;
         tdle <= 1'b0;
         tcnt <= 7'h00;
         tbits <= 4'h0;
         tsh <= 12'hfff;
      end else begin
         if (ttick) begin
            if (tbusy && tcnt != 7'h00)
               tcnt <= tcnt - 7'h01;
            else if (tbusy && tbits != 4'h1) begin
               tsh <= {1'b1, tsh[11:1]};
               tbits <= tbits - 4'h1;
               tcnt <= (asy && tbits == 4'h2) ? stopt - 7'h01 : fact - 7'h01;
            end else if (tgo) begin
               // Frame: start, data, parity, stop ones in async
               tsh <= asy ? ({2'h0, tbody, 1'b0} | (12'hfff << rtot))
                          : {3'h0, tbody};
               tbits <= asy ? rtot + 4'h1 : clen + {3'h0, par};
               tcnt <= fact - 7'h01;
               tbusy <= 1'b1;
               thr_full <= 1'b0;
               tdle <= tfill & mr1[`SSI_M1_TRANS] & ~tdle;
            end else
               tbusy <= 1'b0;
         end
         if (!tx_en)
            tbusy <= 1'b0;
         if (wr_end && lat_a == `SSI_A_DATA) begin
            transmit_holding_reg <= lat_d;
            thr_full <= 1'b1;
         end
      end
   end

   // Serial output and modem pins
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txd_o <= 1'b1;
         dtr_n_o <= 1'b1;
         rts_n_o <= 1'b1;
         tx_empty_n_o <= 1'b1;
         rx_char_waiting_n_o <= 1'b1;
         tx_holding_free_n_o <= 1'b1;
      end else begin
         if (lp == `SSI_LP_REMOTE || (lp == `SSI_LP_ECHO && asy))
            txd_o <= rxd_s;
         else if (!tx_en || lp == `SSI_LP_LOCAL)
            txd_o <= 1'b1;
         else
            txd_o <= cmd[`SSI_C_BRK] ? 1'b0 : tline;
         dtr_n_o <= ~cmd[`SSI_C_DTR];
         rts_n_o <= ~cmd[`SSI_C_RTS];
         tx_empty_n_o <= ~(tx_en & ~tbusy & ~thr_full);
         rx_char_waiting_n_o <= ~rx_full;
         tx_holding_free_n_o <= ~(tx_en & ~thr_full);
      end
   end
endmodule

// ==== test/ssi_top_properties.sv ====
// Purpose: Port level checks on the serial interface block
// Assumes: Bus pins pass a two stage synchroniser before use
// Notes: Quiet windows of eight cycles cover the synchroniser lag
`timescale 1ns/10ps
module ssi_top_properties (
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // Processor bus
   input wire cs_n_i,
   input wire rw_i,
   input wire [1:0] register_select_i,
   input wire [7:0] host_data_bus_i,
   input wire [7:0] host_data_bus_o,
   input wire host_data_bus_oe_o,
   // Serial line and modem
   input wire rxd_i,
   input wire tx_clk_i,
   input wire rx_clk_i,
   input wire txd_o,
   input wire cts_n_i,
   input wire dcd_n_i,
   input wire dsr_n_i,
   input wire dtr_n_o,
   input wire rts_n_o,
   input wire tx_empty_n_o,
   input wire rx_char_waiting_n_o,
   input wire tx_holding_free_n_o,
   input wire break_det_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Steps of a bus cycle as seen after the synchroniser
   sequence quiet_bus;
      cs_n_i [*8];
   endsequence
   sequence read_held;
      (!cs_n_i && !rw_i) [*6];
   endsequence
   // Bus driver only on a selected read
   idle_no_drive_a: assert property (quiet_bus |-> !host_data_bus_oe_o)
      else $error("bus driven while deselected");
   write_no_drive_a: assert property (rw_i [*6] |-> !host_data_bus_oe_o)
      else $error("bus driven during write");
   read_drives_a: assert property (read_held |-> host_data_bus_oe_o)
      else $error("bus not driven during read");
   drive_cause_a: assert property ($rose(host_data_bus_oe_o) |->
      !$past(cs_n_i, 2) && !$past(rw_i, 2))
      else $error("bus drive without selected read");
   // Idle outputs straight out of reset
   reset_idle_a: assert property ($rose(rst_n_i) |-> txd_o && !host_data_bus_oe_o &&
      rx_char_waiting_n_o && tx_holding_free_n_o && !break_det_o)
      else $error("outputs not idle after reset");
   // Flags only change through bus accesses or the line
   rx_wait_holds_a: assert property (quiet_bus ##0 !rx_char_waiting_n_o ##1 cs_n_i
      |-> !rx_char_waiting_n_o)
      else $error("waiting character lost without read");
   tx_free_holds_a: assert property (quiet_bus ##0 !tx_holding_free_n_o ##1 cs_n_i
      |-> !tx_holding_free_n_o)
      else $error("holding register busy without load");
   modem_hold_a: assert property (quiet_bus |=> $stable(dtr_n_o) && $stable(rts_n_o))
      else $error("modem outputs moved without command");
endmodule
bind ssi_top ssi_top_properties u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
   .rw_i(rw_i), .register_select_i(register_select_i), .host_data_bus_i(host_data_bus_i),
   .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
   .rxd_i(rxd_i), .tx_clk_i(tx_clk_i), .rx_clk_i(rx_clk_i), .txd_o(txd_o),
   .cts_n_i(cts_n_i), .dcd_n_i(dcd_n_i), .dsr_n_i(dsr_n_i), .dtr_n_o(dtr_n_o),
   .rts_n_o(rts_n_o), .tx_empty_n_o(tx_empty_n_o), .rx_char_waiting_n_o(rx_char_waiting_n_o),
   .tx_holding_free_n_o(tx_holding_free_n_o), .break_det_o(break_det_o));

// ==== test/ssi_line_model.sv ====
// Purpose: Modem side of the serial line with an external bit clock
// Assumes: 1X asynchronous frames, eight data bits, no parity
// Notes: Data moves on falling bit clock edges, sampled on rising ones
`timescale 1ns/10ps
module ssi_line_model #(
   parameter HALF = 160
) (
   // Bit clock for both clock pins
   output reg bit_clk_o,
   // Serial lines
   output reg rxd_o,
   input wire txd_i
);
   // Line at mark until a frame is sent
   initial begin
      bit_clk_o = 1'b0;
      rxd_o = 1'b1;
   end
   // External modem clock runs free
   always #(HALF) bit_clk_o = ~bit_clk_o;
   // Start, eight data bits LSB first, one stop
   task send_char(input [7:0] d);
      integer i;
      begin
         @(negedge bit_clk_o) rxd_o = 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            @(negedge bit_clk_o) rxd_o = d[i];
         end
         @(negedge bit_clk_o) rxd_o = 1'b1;
         @(negedge bit_clk_o);
      end
   endtask
   // Rising edge sampling keeps clear of the transmitter's change point
   task recv_char(output [7:0] d, output ok);
      integer i;
      integer n;
      begin
         n = 0;
         @(posedge bit_clk_o);
         while (txd_i !== 1'b0 && n < 100) begin
            n = n + 1;
            @(posedge bit_clk_o);
         end
         for (i = 0; i < 8; i = i + 1) begin
            @(posedge bit_clk_o) d[i] = txd_i;
         end
         @(posedge bit_clk_o) ok = (n < 100) && (txd_i === 1'b1);
      end
   endtask
endmodule

// ==== test/ssi_top_tb.sv ====
// Purpose: Self checking bench for the serial interface block
// Assumes: External 1X clocks, 8N1 frames, modem inputs held active
// Notes: Bench drives on falling edges; each access holds select 6 cycles
`timescale 1ns/10ps
module ssi_top_tb;
   reg mclk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg cs_n = 1'b1;
   reg rw = 1'b1;
   reg [1:0] sel = 2'h0;
   reg [7:0] bench_d = 8'h00;
   reg modem_n = 1'b0;
   wire [7:0] bus_w;
   wire [7:0] dout;
   wire oe, rxd, bclk, txd, dtr_n, rts_n, txe_n, rxw_n, txf_n, brk;
   integer fail_count = 0;
   integer checks_done = 0;
   integer cycles = 0;
   reg [7:0] q;
   reg [7:0] a;
   reg [7:0] b;
   reg ok_a;
   reg ok_b;
   // Shared wire: device wins while it drives
   assign bus_w = oe ? dout : bench_d;
   always #5 mclk_i = ~mclk_i;
   ssi_top #(.REF_HZ(1600000)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
      .rw_i(rw), .register_select_i(sel), .host_data_bus_i(bus_w), .host_data_bus_o(dout),
      .host_data_bus_oe_o(oe), .rxd_i(rxd), .tx_clk_i(bclk), .rx_clk_i(bclk), .txd_o(txd),
      .cts_n_i(modem_n), .dcd_n_i(modem_n), .dsr_n_i(modem_n), .dtr_n_o(dtr_n),
      .rts_n_o(rts_n), .tx_empty_n_o(txe_n), .rx_char_waiting_n_o(rxw_n),
      .tx_holding_free_n_o(txf_n), .break_det_o(brk));
   ssi_line_model u_line (.bit_clk_o(bclk), .rxd_o(rxd), .txd_i(txd));
   task check(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // One access; the driver must follow rw while selected
   task bus(input w, input [1:0] ad, input [7:0] d, output [7:0] r);
      begin
         @(negedge mclk_i);
         cs_n = 1'b0;
         rw = w;
         sel = ad;
         bench_d = d;
         repeat (6) @(negedge mclk_i);
         r = dout;
         check({7'h0, oe}, {7'h0, ~w});
         cs_n = 1'b1;
         repeat (6) @(negedge mclk_i);
         bench_d = ~d;
         check({7'h0, oe}, 8'h00);
      end
   endtask
   task t_reset;
      begin
         check({oe, txd, dtr_n, rts_n, txe_n, rxw_n, txf_n, brk}, 8'h7e);
         rw = 1'b0;
         repeat (8) @(negedge mclk_i);
         check({7'h0, oe}, 8'h00);
         rw = 1'b1;
         $display("t_reset done");
      end
   endtask
   task t_config;
      begin
         bus(1'b0, 2'h3, 8'h00, q);
         bus(1'b1, 2'h2, 8'h4d, q);
         bus(1'b1, 2'h2, 8'h00, q);
         bus(1'b1, 2'h3, 8'h27, q);
         bus(1'b0, 2'h3, 8'h00, q);
         check(q, 8'h27);
         check({6'h0, dtr_n, rts_n}, 8'h00);
         check({7'h0, txf_n}, 8'h00);
         $display("t_config done");
      end
   endtask
   // Two back to back characters while the first still shifts
   task t_tx;
      begin
         fork
            begin
               u_line.recv_char(a, ok_a);
               u_line.recv_char(b, ok_b);
            end
            begin
               bus(1'b1, 2'h0, 8'ha5, q);
               // Second load only once the first has left the holding register
               wait (txf_n === 1'b0);
               bus(1'b1, 2'h0, 8'h5a, q);
               check({7'h0, txf_n}, 8'h01);
            end
         join
         check(a, 8'ha5);
         check(b, 8'h5a);
         check({6'h0, ok_a, ok_b}, 8'h03);
         $display("t_tx done");
      end
   endtask
   task wait_char;
      integer n;
      begin
         n = 0;
         while (rxw_n !== 1'b0 && n < 600) begin
            @(negedge mclk_i);
            n = n + 1;
         end
      end
   endtask
   task t_rx;
      begin
         u_line.send_char(8'h3c);
         wait_char;
         check({7'h0, rxw_n}, 8'h00);
         bus(1'b0, 2'h1, 8'h00, q);
         check(q & 8'h02, 8'h02);
         bus(1'b0, 2'h0, 8'h00, q);
         check(q, 8'h3c);
         check({7'h0, rxw_n}, 8'h01);
         $display("t_rx done");
      end
   endtask
   // Second character lands on an unread one, then receiver is shut off
   task t_overrun;
      begin
         u_line.send_char(8'h11);
         u_line.send_char(8'h22);
         wait_char;
         bus(1'b0, 2'h1, 8'h00, q);
         check(q & 8'h10, 8'h10);
         bus(1'b1, 2'h3, 8'h37, q);
         bus(1'b0, 2'h1, 8'h00, q);
         check(q & 8'h10, 8'h00);
         check({7'h0, rxw_n}, 8'h00);
         bus(1'b1, 2'h3, 8'h00, q);
         check({5'h0, txd, txf_n, rxw_n}, 8'h07);
         $display("t_overrun done");
      end
   endtask
   // Local loop returns data inside while the line stays at mark
   task t_loop;
      begin
         bus(1'b1, 2'h3, 8'ha7, q);
         bus(1'b1, 2'h0, 8'h96, q);
         wait_char;
         check({7'h0, txd}, 8'h01);
         bus(1'b0, 2'h0, 8'h00, q);
         check(q, 8'h96);
         repeat (40) @(negedge mclk_i);
         check({7'h0, txe_n}, 8'h00);
         $display("t_loop done");
      end
   endtask
   // Hang guard well above the expected run
   always @(posedge mclk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t timeout", $time);
         finish_test;
      end
   end
   initial begin
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      t_reset;
      t_config;
      t_tx;
      t_rx;
      t_overrun;
      t_loop;
      finish_test;
   end
endmodule
